// >>> inc/ams_pkg.sv
// acquisition mode select: register map, mode bits, error codes and carrier types
package ams_pkg;

    // ==========================================================
    // register numbers
    localparam logic [15:0] AMS_REG_MODE_SEL = 16'h251C;
    localparam logic [15:0] AMS_REG_MODE_MAP = 16'h251D;

    // ==========================================================
    // mode bits, one bit per acquisition mode
    localparam logic [31:0] MODE_MEM_ONE_TRIGGER = 32'h0000_0001;
    localparam logic [31:0] MODE_MEM_MANY_TRIGGERS = 32'h0000_0002;
    localparam logic [31:0] MODE_MEM_GATED = 32'h0000_0004;
    localparam logic [31:0] MODE_MEM_DUAL_RATE = 32'h0000_0008;
    localparam logic [31:0] MODE_STREAM_ONE_TRIGGER = 32'h0000_0010;
    localparam logic [31:0] MODE_STREAM_MANY_TRIGGERS = 32'h0000_0020;
    localparam logic [31:0] MODE_STREAM_GATED = 32'h0000_0040;
    localparam logic [31:0] MODE_STREAM_DUAL_RATE = 32'h0000_0080;
    localparam logic [31:0] MODE_MEM_SEGMENT_STATISTICS = 32'h0001_0000;
    localparam logic [31:0] MODE_MEM_BLOCK_AVERAGING = 32'h0002_0000;
    localparam logic [31:0] MODE_STREAM_SEGMENT_STATISTICS = 32'h0010_0000;
    localparam logic [31:0] MODE_STREAM_BLOCK_AVERAGING = 32'h0020_0000;
    localparam logic [31:0] MODE_MEM_BOXCAR_AVERAGING = 32'h0080_0000;
    localparam logic [31:0] MODE_STREAM_BOXCAR_AVERAGING = 32'h0100_0000;
    localparam logic [31:0] MODE_STREAM_ONE_TRIGGER_WITH_MONITOR = 32'h0200_0000;

    localparam logic [31:0] MODE_STREAM_MASK = MODE_STREAM_ONE_TRIGGER | MODE_STREAM_MANY_TRIGGERS |
        MODE_STREAM_GATED | MODE_STREAM_DUAL_RATE | MODE_STREAM_SEGMENT_STATISTICS |
        MODE_STREAM_BLOCK_AVERAGING | MODE_STREAM_BOXCAR_AVERAGING | MODE_STREAM_ONE_TRIGGER_WITH_MONITOR;
    localparam logic [31:0] MODE_MEM_MASK = MODE_MEM_ONE_TRIGGER | MODE_MEM_MANY_TRIGGERS |
        MODE_MEM_GATED | MODE_MEM_DUAL_RATE | MODE_MEM_SEGMENT_STATISTICS |
        MODE_MEM_BLOCK_AVERAGING | MODE_MEM_BOXCAR_AVERAGING;
    localparam logic [31:0] MODE_VALID_MASK = MODE_MEM_MASK | MODE_STREAM_MASK;
    localparam logic [31:0] MODE_BOXCAR_MASK = MODE_MEM_BOXCAR_AVERAGING | MODE_STREAM_BOXCAR_AVERAGING;

    // ==========================================================
    // reset values and firmware gate
    localparam logic [31:0] MODE_RESET = MODE_MEM_ONE_TRIGGER;
    localparam logic [31:0] SPAN_RESET = 32'h0000_0000;
    localparam logic [7:0] BOXCAR_MIN_FW = 8'h1D;

    // ==========================================================
    // carrier types
    typedef enum logic [2:0] {
        AMS_OK = 3'h0,
        AMS_ERR_NOT_ONEHOT = 3'h1,
        AMS_ERR_UNSUPPORTED = 3'h2,
        AMS_ERR_READ_ONLY = 3'h3,
        AMS_ERR_UNMAPPED = 3'h4
    } ams_err_t;

    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [31:0] wdata;
    } ams_req_t;

    typedef struct packed {
        ams_err_t err;
        logic [31:0] rdata;
    } ams_rsp_t;

    typedef struct packed {
        logic stream;
        logic one_trigger;
        logic many_triggers;
        logic fixed_segments;
        logic gated;
        logic dual_rate;
        logic slow_stream;
        logic seg_stats;
        logic block_avg;
        logic boxcar;
    } ams_ctl_t;

    // ==========================================================
    // exactly one bit set, and that bit names a mode
    function automatic logic ams_mode_ok(input logic [31:0] m);
        return $onehot(m) && ((m & MODE_VALID_MASK) != 32'h0000_0000);
    endfunction

    // modes this card may select, boxcar only on new enough firmware
    function automatic logic [31:0] ams_cap(input logic [31:0] straps, input logic [7:0] fw);
        logic [31:0] c;
        c = straps & MODE_VALID_MASK;
        if (fw < BOXCAR_MIN_FW) begin
            c = c & ~MODE_BOXCAR_MASK;
        end
        return c;
    endfunction

endpackage

// >>> core/ams_buf.sv
// two-entry response buffer with registered outputs and registered ready
`timescale 1ns/10ps
module ams_buf (
    input wire logic mclk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input ams_pkg::ams_rsp_t in_data,
    output logic out_valid,
    input wire logic out_ready,
    output ams_pkg::ams_rsp_t out_data
);

    logic out_v_r;
    logic skid_v_r;
    ams_pkg::ams_rsp_t out_r;
    ams_pkg::ams_rsp_t skid_r;
    logic push;
    logic load;
    logic in_ready_r;

    // ready drops only while the second slot holds a word
    assign push = in_valid && !skid_v_r;
    assign load = !out_v_r || out_ready;
    assign in_ready = in_ready_r;
    assign out_valid = out_v_r;
    assign out_data = out_r;

    // ==========================================================
    // head slot feeds the port, skid slot catches a word during a stall
    always_ff @(posedge mclk) begin
        if (srst) begin
            out_v_r <= 1'b0;
            skid_v_r <= 1'b0;
            out_r <= '0;
            skid_r <= '0;
        end else if (load) begin
            if (skid_v_r) begin
                out_r <= skid_r;
                out_v_r <= 1'b1;
                skid_v_r <= 1'b0;
            end else begin
                out_r <= in_data;
                out_v_r <= push;
            end
        end else if (push) begin
            skid_r <= in_data;
            skid_v_r <= 1'b1;
        end
    end

    // ==========================================================
    // ready is the skid slot's next emptiness, kept in a flop so the port sees no gate
    always_ff @(posedge mclk) begin
        if (srst) begin
            in_ready_r <= 1'b1;
        end else begin
            in_ready_r <= load || !(push || skid_v_r);
        end
    end

endmodule

// >>> core/ams_top.sv
// acquisition mode select: mode register, capability map and decoded mode controls
//
// Operation
// - mode register is a bitmap, one bit per mode, single bit set.
// - writes without exactly one valid mode bit are refused with an error code.
// - mode register reads and writes; a read returns the mode in use.
// - read-only capability map shows supported modes at the same bit positions.
// - streaming modes use all installed memory as a continuous buffer.
// - bit 1h selects memory acquisition of one trigger event.
// - bit 2h selects memory acquisition of many equal-length segments.
// - bit 4h selects gated memory acquisition.
// - bit 8h selects dual-rate memory acquisition with slow continuous stream.
// - bit 10000h selects multi-trigger memory acquisition with segment statistics.
// - bit 20000h selects multi-trigger memory acquisition with block averaging.
// - bit 800000h enables memory boxcar averaging, needs recent firmware.
// - bit 10h selects streaming acquisition of one trigger event.
// - bit 20h selects streaming acquisition of many trigger events.
// - bit 40h selects gated streaming acquisition.
// - bit 80h selects streaming multi-trigger plus slow continuous stream.
// - bit 100000h enables segment statistics during streaming.
// - bit 200000h enables block averaging during streaming.
// - bit 1000000h enables streaming boxcar averaging, same firmware need.
// - bit 2000000h selects single-trigger streaming plus slow monitor stream.
`timescale 1ns/10ps
module ams_top (
    input wire logic mclk,
    input wire logic srst,
    input wire logic req_valid,
    output logic req_ready,
    input ams_pkg::ams_req_t req,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output ams_pkg::ams_rsp_t rsp,
    input wire logic [31:0] card_modes,
    input wire logic [7:0] fw_version,
    input wire logic [31:0] mem_words,
    output ams_pkg::ams_ctl_t mode_ctl,
    output logic [31:0] buffer_span,
    output logic mode_changed
);

    // ==========================================================
    // decode of a one-hot mode word into datapath controls
    function automatic ams_pkg::ams_ctl_t ams_decode(input logic [31:0] m);
        ams_pkg::ams_ctl_t c;
        c = '0;
        c.stream = (m & ams_pkg::MODE_STREAM_MASK) != 32'h0000_0000;
        c.one_trigger = (m & (ams_pkg::MODE_MEM_ONE_TRIGGER | ams_pkg::MODE_STREAM_ONE_TRIGGER |
            ams_pkg::MODE_STREAM_ONE_TRIGGER_WITH_MONITOR)) != 32'h0000_0000;
        c.many_triggers = (m & (ams_pkg::MODE_MEM_MANY_TRIGGERS | ams_pkg::MODE_STREAM_MANY_TRIGGERS |
            ams_pkg::MODE_MEM_DUAL_RATE | ams_pkg::MODE_STREAM_DUAL_RATE |
            ams_pkg::MODE_MEM_SEGMENT_STATISTICS | ams_pkg::MODE_MEM_BLOCK_AVERAGING))
            != 32'h0000_0000;
        c.fixed_segments = (m & ams_pkg::MODE_MEM_MANY_TRIGGERS) != 32'h0000_0000;
        c.gated = (m & (ams_pkg::MODE_MEM_GATED | ams_pkg::MODE_STREAM_GATED)) != 32'h0000_0000;
        c.dual_rate = (m & (ams_pkg::MODE_MEM_DUAL_RATE | ams_pkg::MODE_STREAM_DUAL_RATE))
            != 32'h0000_0000;
        // the monitor stream reuses the dual-rate slow path unchanged
        c.slow_stream = (m & (ams_pkg::MODE_MEM_DUAL_RATE | ams_pkg::MODE_STREAM_DUAL_RATE |
            ams_pkg::MODE_STREAM_ONE_TRIGGER_WITH_MONITOR)) != 32'h0000_0000;
        c.seg_stats = (m & (ams_pkg::MODE_MEM_SEGMENT_STATISTICS |
            ams_pkg::MODE_STREAM_SEGMENT_STATISTICS)) != 32'h0000_0000;
        c.block_avg = (m & (ams_pkg::MODE_MEM_BLOCK_AVERAGING |
            ams_pkg::MODE_STREAM_BLOCK_AVERAGING)) != 32'h0000_0000;
        c.boxcar = (m & ams_pkg::MODE_BOXCAR_MASK) != 32'h0000_0000;
        return c;
    endfunction

    // ==========================================================
    // declarations
    logic [31:0] mode_r;
    logic [31:0] mode_nxt;
    logic [31:0] cap_now;
    logic take;
    logic buf_in_ready;
    ams_pkg::ams_rsp_t rsp_nxt;
    ams_pkg::ams_ctl_t ctl_r;
    logic [31:0] span_r;
    logic changed_r;

    // a request is taken only when the buffer has a slot for its answer
    assign take = req_valid && buf_in_ready;
    assign req_ready = buf_in_ready;
    assign mode_ctl = ctl_r;
    assign buffer_span = span_r;
    assign mode_changed = changed_r;

    // capability follows the straps live; boxcar hidden on old firmware
    assign cap_now = ams_pkg::ams_cap(card_modes, fw_version);

    // ==========================================================
    // register access: decide the answer and the next mode
    always_comb begin
        mode_nxt = mode_r;
        rsp_nxt = '{err: ams_pkg::AMS_OK, rdata: 32'h0000_0000};
        if (take) begin
            if (req.addr == ams_pkg::AMS_REG_MODE_SEL) begin
                if (!req.write) begin
                    rsp_nxt.rdata = mode_r;
                end else if (!ams_pkg::ams_mode_ok(req.wdata)) begin
                    rsp_nxt.err = ams_pkg::AMS_ERR_NOT_ONEHOT;
                end else if ((req.wdata & cap_now) == 32'h0000_0000) begin
                    rsp_nxt.err = ams_pkg::AMS_ERR_UNSUPPORTED;
                end else begin
                    mode_nxt = req.wdata;
                end
            end else if (req.addr == ams_pkg::AMS_REG_MODE_MAP) begin
                if (req.write) begin
                    rsp_nxt.err = ams_pkg::AMS_ERR_READ_ONLY;
                end else begin
                    rsp_nxt.rdata = cap_now;
                end
            end else begin
                rsp_nxt.err = ams_pkg::AMS_ERR_UNMAPPED;
            end
        end
    end

    // ==========================================================
    // mode register, only a fully checked write changes it
    always_ff @(posedge mclk) begin
        if (srst) begin
            mode_r <= ams_pkg::MODE_RESET;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // controls are registered from the next mode so they move with mode_r
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctl_r <= ams_decode(ams_pkg::MODE_RESET);
        end else begin
            ctl_r <= ams_decode(mode_nxt);
        end
    end

    // whole installed memory is the span in every mode; ctl.stream says wrap or stop
    always_ff @(posedge mclk) begin
        if (srst) begin
            span_r <= ams_pkg::SPAN_RESET;
        end else begin
            span_r <= mem_words;
        end
    end

    // one-cycle pulse when an accepted write really moves the mode
    always_ff @(posedge mclk) begin
        if (srst) begin
            changed_r <= 1'b0;
        end else begin
            changed_r <= mode_nxt != mode_r;
        end
    end

    // ==========================================================
    // answers wait here so a stalled reader loses none
    ams_buf u_buf (
        .mclk(mclk),
        .srst(srst),
        .in_valid(take),
        .in_ready(buf_in_ready),
        .in_data(rsp_nxt),
        .out_valid(rsp_valid),
        .out_ready(rsp_ready),
        .out_data(rsp)
    );

    // ==========================================================
    // checks
    default clocking ams_cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    logic wr_sel;
    logic rd_sel;
    assign wr_sel = take && req.write && (req.addr == ams_pkg::AMS_REG_MODE_SEL);
    assign rd_sel = take && !req.write && (req.addr == ams_pkg::AMS_REG_MODE_SEL);

    AST_MODE_ONEHOT: assert property ($onehot(mode_r) && ((mode_r & ~ams_pkg::MODE_VALID_MASK) == 32'h0000_0000))
        else $error("mode register not a single valid bit");

    AST_BAD_WRITE_REFUSED: assert property (
        wr_sel && !ams_pkg::ams_mode_ok(req.wdata) && !rsp_valid
        |=> rsp_valid && (rsp.err == ams_pkg::AMS_ERR_NOT_ONEHOT) && $stable(mode_r))
        else $error("bad mode write not refused");

    AST_READ_GIVES_MODE: assert property (
        rd_sel && !rsp_valid |=> rsp_valid && (rsp.rdata == $past(mode_r)) && (rsp.err == ams_pkg::AMS_OK))
        else $error("mode read wrong");

    AST_GOOD_WRITE_TAKES: assert property (
        wr_sel && ams_pkg::ams_mode_ok(req.wdata) && ((req.wdata & cap_now) != 32'h0000_0000)
        |=> (mode_r == $past(req.wdata)) && mode_changed == ($past(req.wdata) != $past(mode_r)))
        else $error("good mode write not applied");

    AST_MAP_READ_ONLY: assert property (
        take && (req.addr == ams_pkg::AMS_REG_MODE_MAP) && !rsp_valid
        |=> rsp_valid && $stable(mode_r) && ((rsp.rdata & ~ams_pkg::MODE_VALID_MASK) == 32'h0000_0000)
        && ((rsp.rdata & ~$past(card_modes)) == 32'h0000_0000))
        else $error("capability map misbehaves");

    AST_STREAM_WRAPS: assert property (
        ctl_r.stream == ((mode_r & ams_pkg::MODE_STREAM_MASK) != 32'h0000_0000))
        else $error("stream control out of step with mode");

    AST_GATED_CTL: assert property (
        $rose(ctl_r.gated) |-> (mode_r == ams_pkg::MODE_MEM_GATED) || (mode_r == ams_pkg::MODE_STREAM_GATED))
        else $error("gate control without gated mode");

    AST_MONITOR_CTL: assert property (
        mode_r == ams_pkg::MODE_STREAM_ONE_TRIGGER_WITH_MONITOR
        |-> ctl_r.stream && ctl_r.one_trigger && ctl_r.slow_stream && !ctl_r.dual_rate)
        else $error("monitor mode controls wrong");

    AST_DUAL_RATE_CTL: assert property (
        mode_r == ams_pkg::MODE_MEM_DUAL_RATE |-> !ctl_r.stream && ctl_r.dual_rate && ctl_r.many_triggers)
        else $error("dual-rate controls wrong");

    AST_OLD_FW_NO_BOXCAR: assert property (
        wr_sel && ((req.wdata & ams_pkg::MODE_BOXCAR_MASK) != 32'h0000_0000)
        && (fw_version < ams_pkg::BOXCAR_MIN_FW) |=> $stable(mode_r) ##1 !ctl_r.boxcar)
        else $error("boxcar taken on old firmware");

    AST_UNSUPPORTED_KEPT: assert property (
        wr_sel && ams_pkg::ams_mode_ok(req.wdata) && ((req.wdata & cap_now) == 32'h0000_0000)
        |=> $stable(mode_r) && !mode_changed)
        else $error("unsupported mode accepted");

    AST_STALL_HOLDS: assert property (
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
        else $error("answer lost under stall");

    // ==========================================================
    // span, remaining per-mode controls and the read-only and unsupported answers, one property each; 1h and 10h share one
    AST_SPAN_WHOLE_MEM: assert property (
        !$past(srst) |-> buffer_span == $past(mem_words))
        else $error("span is not the whole memory");

    AST_ONE_TRIGGER_CTL: assert property (
        (mode_r == ams_pkg::MODE_MEM_ONE_TRIGGER) || (mode_r == ams_pkg::MODE_STREAM_ONE_TRIGGER)
        |-> ctl_r.one_trigger && !ctl_r.many_triggers && !ctl_r.slow_stream)
        else $error("one-trigger controls wrong");

    AST_FIXED_SEGMENTS_CTL: assert property (
        mode_r == ams_pkg::MODE_MEM_MANY_TRIGGERS
        |-> ctl_r.many_triggers && ctl_r.fixed_segments && !ctl_r.stream)
        else $error("multi-trigger controls wrong");

    AST_MEM_GATED_CTL: assert property (
        mode_r == ams_pkg::MODE_MEM_GATED |-> ctl_r.gated && !ctl_r.stream && !ctl_r.many_triggers)
        else $error("gated memory controls wrong");

    AST_MEM_STATS_CTL: assert property (
        mode_r == ams_pkg::MODE_MEM_SEGMENT_STATISTICS
        |-> ctl_r.many_triggers && ctl_r.seg_stats && !ctl_r.block_avg && !ctl_r.stream)
        else $error("memory statistics controls wrong");

    AST_MEM_AVG_CTL: assert property (
        mode_r == ams_pkg::MODE_MEM_BLOCK_AVERAGING
        |-> ctl_r.many_triggers && ctl_r.block_avg && !ctl_r.seg_stats && !ctl_r.stream)
        else $error("memory averaging controls wrong");

    AST_MEM_BOXCAR_CTL: assert property (
        mode_r == ams_pkg::MODE_MEM_BOXCAR_AVERAGING |-> ctl_r.boxcar && !ctl_r.stream)
        else $error("memory boxcar controls wrong");

    AST_STREAM_MULTI_CTL: assert property (
        mode_r == ams_pkg::MODE_STREAM_MANY_TRIGGERS
        |-> ctl_r.stream && ctl_r.many_triggers && !ctl_r.fixed_segments)
        else $error("streaming multi-trigger controls wrong");

    AST_STREAM_GATED_CTL: assert property (
        mode_r == ams_pkg::MODE_STREAM_GATED |-> ctl_r.stream && ctl_r.gated)
        else $error("gated streaming controls wrong");

    AST_STREAM_DUAL_CTL: assert property (
        mode_r == ams_pkg::MODE_STREAM_DUAL_RATE
        |-> ctl_r.stream && ctl_r.dual_rate && ctl_r.slow_stream && ctl_r.many_triggers)
        else $error("dual-rate streaming controls wrong");

    AST_STREAM_STATS_CTL: assert property (
        mode_r == ams_pkg::MODE_STREAM_SEGMENT_STATISTICS |-> ctl_r.stream && ctl_r.seg_stats)
        else $error("streaming statistics controls wrong");

    AST_STREAM_AVG_CTL: assert property (
        mode_r == ams_pkg::MODE_STREAM_BLOCK_AVERAGING |-> ctl_r.stream && ctl_r.block_avg)
        else $error("streaming averaging controls wrong");

    AST_STREAM_BOXCAR_CTL: assert property (
        mode_r == ams_pkg::MODE_STREAM_BOXCAR_AVERAGING |-> ctl_r.stream && ctl_r.boxcar)
        else $error("streaming boxcar controls wrong");

    // error answers are checked only from an empty buffer, where the next cycle shows them
    AST_MAP_WRITE_REFUSED: assert property (
        take && req.write && (req.addr == ams_pkg::AMS_REG_MODE_MAP) && !rsp_valid
        |=> rsp_valid && (rsp.err == ams_pkg::AMS_ERR_READ_ONLY) && $stable(mode_r))
        else $error("capability write not refused");

    AST_UNSUPPORTED_ERR: assert property (
        wr_sel && ams_pkg::ams_mode_ok(req.wdata) && ((req.wdata & cap_now) == 32'h0000_0000) && !rsp_valid
        |=> rsp_valid && (rsp.err == ams_pkg::AMS_ERR_UNSUPPORTED))
        else $error("unsupported mode gave wrong answer");

    COV_STREAM_SELECT: cover property (wr_sel ##1 mode_changed && ctl_r.stream);
    COV_REFUSED: cover property (rsp_valid && rsp.err == ams_pkg::AMS_ERR_NOT_ONEHOT);
    COV_BUFFER_FULL: cover property (rsp_valid && !rsp_ready ##1 !req_ready);
    COV_READ_BACK: cover property (wr_sel ##1 rd_sel);
    COV_BOXCAR_SELECT: cover property (mode_changed && ctl_r.boxcar);

endmodule

// >>> dv/tb_top.sv
// self-checking testbench for the acquisition mode select block
`timescale 1ns/10ps
module tb_top;
    logic mclk, srst, req_valid, req_ready, rsp_valid, rsp_ready, mode_changed, mc_seen;
    ams_pkg::ams_req_t req;
    ams_pkg::ams_rsp_t rsp;
    ams_pkg::ams_ctl_t mode_ctl;
    logic [31:0] card_modes, mem_words, buffer_span;
    logic [7:0] fw_version;
    int fail_count, tests_run, cycles;

    ams_top u_dut (.mclk(mclk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .card_modes(card_modes),
        .fw_version(fw_version), .mem_words(mem_words), .mode_ctl(mode_ctl),
        .buffer_span(buffer_span), .mode_changed(mode_changed));

    // ==========================================================
    // clock, reset and hang guard
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // ceiling is far above the 120 or so cycles the scenarios need
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end

    // ==========================================================
    // comparison and bus helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (fail_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // request stays up after it is taken so a following send can chain back to back
    task automatic send(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(negedge mclk);
        req_valid = 1'b1;
        req.write = w;
        req.addr = a;
        req.wdata = d;
        while (req_ready !== 1'b1) @(negedge mclk);
        @(posedge mclk);
    endtask
    task automatic expect_rsp(input ams_pkg::ams_err_t e, input logic [31:0] d, input logic chk_d);
        @(negedge mclk);
        req_valid = 1'b0;
        rsp_ready = 1'b1;
        mc_seen = mode_changed;
        while (rsp_valid !== 1'b1) @(negedge mclk);
        check(32'(rsp.err), 32'(e));
        if (chk_d) check(rsp.rdata, d);
        @(posedge mclk);
    endtask
    task automatic xact(input logic w, input logic [15:0] a, input logic [31:0] d, input ams_pkg::ams_err_t e,
        input logic [31:0] exp_d);
        send(w, a, d);
        expect_rsp(e, exp_d, !w || e == ams_pkg::AMS_OK);
    endtask

    // ==========================================================
    // expected decoded controls, from the mode descriptions
    function automatic logic [31:0] ctl_bits(input ams_pkg::ams_ctl_t c);
        return {22'h0, c.stream, c.one_trigger, c.many_triggers, c.fixed_segments, c.gated, c.dual_rate,
            c.slow_stream, c.seg_stats, c.block_avg, c.boxcar};
    endfunction
    function automatic logic [31:0] exp_ctl(input logic [31:0] m);
        return {22'h0, (m & ams_pkg::MODE_STREAM_MASK) != 32'h0, m inside {32'h1, 32'h10, 32'h2000000},
            m inside {32'h2, 32'h8, 32'h20, 32'h80, 32'h10000, 32'h20000}, m == 32'h2, m inside {32'h4, 32'h40},
            m inside {32'h8, 32'h80}, m inside {32'h8, 32'h80, 32'h2000000}, m inside {32'h10000, 32'h100000},
            m inside {32'h20000, 32'h200000}, m inside {32'h800000, 32'h1000000}};
    endfunction

    // ==========================================================
    // scenarios
    task automatic reset_values();
        @(negedge mclk);
        check(ctl_bits(mode_ctl), exp_ctl(32'h1));
        check({31'h0, mode_changed | rsp_valid}, 32'h0);
        check({31'h0, req_ready}, 32'h1);
        check(buffer_span, mem_words);
        xact(1'b0, ams_pkg::AMS_REG_MODE_SEL, 32'h0, ams_pkg::AMS_OK, 32'h1);
    endtask
    // every mode in turn, each a change, one-trigger last so the first differs from reset; then 1h again, no pulse
    task automatic all_modes();
        logic [31:0] modes [15];
        logic [31:0] prev;
        modes = '{32'h2, 32'h4, 32'h8, 32'h10000, 32'h20000, 32'h800000, 32'h10, 32'h20, 32'h40, 32'h80,
            32'h100000, 32'h200000, 32'h1000000, 32'h2000000, 32'h1};
        prev = 32'h1;
        foreach (modes[i]) begin
            xact(1'b1, ams_pkg::AMS_REG_MODE_SEL, modes[i], ams_pkg::AMS_OK, 32'h0);
            check({31'h0, mc_seen}, {31'h0, modes[i] != prev});
            check(ctl_bits(mode_ctl), exp_ctl(modes[i]));
            check(buffer_span, mem_words);
            xact(1'b0, ams_pkg::AMS_REG_MODE_SEL, 32'h0, ams_pkg::AMS_OK, modes[i]);
            prev = modes[i];
        end
        xact(1'b1, ams_pkg::AMS_REG_MODE_SEL, 32'h1, ams_pkg::AMS_OK, 32'h0);
        check({31'h0, mc_seen}, 32'h0);
    endtask
    // refused writes leave mode 1h in place
    task automatic refusals();
        logic [31:0] bad [5];
        bad = '{32'h0, 32'h3, 32'h100, 32'h80000000, 32'h11};
        @(negedge mclk);
        fw_version = 8'h1C;
        xact(1'b0, ams_pkg::AMS_REG_MODE_MAP, 32'h0, ams_pkg::AMS_OK,
            ams_pkg::MODE_VALID_MASK & ~ams_pkg::MODE_BOXCAR_MASK);
        xact(1'b1, ams_pkg::AMS_REG_MODE_SEL, 32'h800000, ams_pkg::AMS_ERR_UNSUPPORTED, 32'h0);
        xact(1'b1, ams_pkg::AMS_REG_MODE_SEL, 32'h1000000, ams_pkg::AMS_ERR_UNSUPPORTED, 32'h0);
        @(negedge mclk);
        fw_version = 8'h1D;
        card_modes = ~ams_pkg::MODE_STREAM_GATED;
        xact(1'b0, ams_pkg::AMS_REG_MODE_MAP, 32'h0, ams_pkg::AMS_OK,
            ams_pkg::MODE_VALID_MASK & ~ams_pkg::MODE_STREAM_GATED);
        xact(1'b1, ams_pkg::AMS_REG_MODE_SEL, 32'h40, ams_pkg::AMS_ERR_UNSUPPORTED, 32'h0);
        check({31'h0, mc_seen}, 32'h0);
        foreach (bad[i]) begin
            xact(1'b1, ams_pkg::AMS_REG_MODE_SEL, bad[i], ams_pkg::AMS_ERR_NOT_ONEHOT, 32'h0);
        end
        xact(1'b1, ams_pkg::AMS_REG_MODE_MAP, 32'h2, ams_pkg::AMS_ERR_READ_ONLY, 32'h0);
        xact(1'b0, 16'h2520, 32'h0, ams_pkg::AMS_ERR_UNMAPPED, 32'h0);
        xact(1'b0, ams_pkg::AMS_REG_MODE_SEL, 32'h0, ams_pkg::AMS_OK, 32'h1);
        check(ctl_bits(mode_ctl), exp_ctl(32'h1));
    endtask
    // reader stalls: two answers fill the buffer, third request waits, nothing is lost
    task automatic stall();
        @(negedge mclk);
        rsp_ready = 1'b0;
        send(1'b1, ams_pkg::AMS_REG_MODE_SEL, 32'h20);
        send(1'b0, ams_pkg::AMS_REG_MODE_SEL, 32'h0);
        @(negedge mclk);
        req.write = 1'b0;
        req.addr = ams_pkg::AMS_REG_MODE_MAP;
        repeat (3) begin
            @(negedge mclk);
            check({30'h0, req_ready, rsp_valid}, 32'h1);
            check(32'(rsp.err), 32'(ams_pkg::AMS_OK));
        end
        check(rsp.rdata, 32'h0);
        // stall ends: the held map read stays up until the freed slot takes it
        rsp_ready = 1'b1;
        @(negedge mclk);
        check({30'h0, req_ready, rsp_valid}, 32'h3);
        check(32'(rsp.err), 32'(ams_pkg::AMS_OK));
        check(rsp.rdata, 32'h20);
        @(negedge mclk);
        req_valid = 1'b0;
        check(32'(rsp.err), 32'(ams_pkg::AMS_OK));
        check(rsp.rdata, ams_pkg::MODE_VALID_MASK & ~ams_pkg::MODE_STREAM_GATED);
        check(ctl_bits(mode_ctl), exp_ctl(32'h20));
        @(negedge mclk);
        mem_words = 32'h0000_1234;
        @(negedge mclk);
        check(buffer_span, 32'h0000_1234);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        srst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        rsp_ready = 1'b1;
        card_modes = 32'hFFFF_FFFF;
        fw_version = 8'h1D;
        mem_words = 32'h0004_0000;
        fail_count = 0;
        tests_run = 0;
        cycles = 0;
        repeat (16) @(negedge mclk);
        srst = 1'b0;
        reset_values();
        all_modes();
        refusals();
        stall();
        close_out();
    end
endmodule
